// ===== kwd_defines.svh
// register map, field positions, codes and reset values of the watchdog
`ifndef KWD_DEFINES_SVH
`define KWD_DEFINES_SVH

// ----------------------------------------------------------------------
// register word indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define KWD_ADR_CTRL        3'h0
`define KWD_ADR_CAUSE       3'h1
`define KWD_ADR_STAT        3'h2
`define KWD_ADR_IRQ_STAT    3'h3
`define KWD_ADR_IRQ_MASK    3'h4
`define KWD_ADR_COUNT       3'h5

// ----------------------------------------------------------------------
// control register fields and codes
// ----------------------------------------------------------------------
`define KWD_CTRL_RESET      8'h53
`define KWD_KEY_MSB         7
`define KWD_KEY_LSB         3
`define KWD_SEL_MSB         2
`define KWD_SEL_LSB         0
`define KWD_KEY_ENABLE      5'h0A
`define KWD_KEY_DISABLE     5'h15

// ----------------------------------------------------------------------
// flag and event bit positions
// ----------------------------------------------------------------------
`define KWD_CAUSE_KEYFAULT  0
`define KWD_STAT_EXPIRY     0
`define KWD_STAT_PDOWN      1
`define KWD_IRQ_EXPIRY      0
`define KWD_IRQ_KEYFAULT    1
`define KWD_IRQ_W           2

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define KWD_SLOW_RC_HZ      32000
`define KWD_BASE_EXP        8
`define KWD_CNT_W           15
`define KWD_KEYFAULT_DELAY  16

`endif

// ===== kwd_pkg.sv
// types shared by the watchdog modules
package kwd_pkg;

	// one-hot state of the key field decoder
	typedef enum logic [2:0] {
		KS_ENABLED  = 3'h1,
		KS_DISABLED = 3'h2,
		KS_FAULT    = 3'h4
	} kwd_key_state_type;

endpackage

// ===== kwd_cnt_if.sv
// link between the watchdog control logic and its period counter
interface kwd_cnt_if #(
	parameter int unsigned CNT_W = 15
);
	logic             tick;
	logic             clear;
	logic             run;
	logic [2:0]       sel;
	logic             expire;
	logic [CNT_W-1:0] count;

	modport ctl (output tick, output clear, output run, output sel,
		input expire, input count);
	modport cnt (input tick, input clear, input run, input sel,
		output expire, output count);
endinterface

// ===== kwd_counter.sv
// period counter of the watchdog, advanced by slow clock ticks
`include "kwd_defines.svh"

module kwd_counter #(
	parameter int unsigned CNT_W = 15
) (
	input  wire logic  clk,
	input  wire logic  rst_n,
	kwd_cnt_if.cnt     port
);

	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	logic             expire;
	logic             next_expire;
	logic [CNT_W-1:0] last;

	// ----------------------------------------------------------------
	// terminal count: low 8+sel bits set
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < CNT_W; i++)
		begin : g_last
			assign last[i] = (i < (`KWD_BASE_EXP + int'(port.sel)));
		end
	endgenerate

	// clear wins over a tick; only ticks advance the count
	always_comb
	begin
		next_count = count;
		next_expire = 1'b0;
		if (port.clear)
		begin
			next_count = '0;
		end
		else if (port.run && port.tick)
		begin
			if (count >= last)
			begin
				next_count = '0;
				next_expire = 1'b1;
			end
			else
			begin
				next_count = count + 1'b1;
			end
		end
	end

	// registers only
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			count <= '0;
			expire <= 1'b0;
		end
		else
		begin
			count <= next_count;
			expire <= next_expire;
		end
	end

	assign port.count = count;
	assign port.expire = expire;

endmodule // kwd_counter

// ===== kwd_watchdog.sv
// keyed watchdog timer with wishbone registers and reset outputs
//
// Overview of operation
// (R1) The count advances only on edges of the slow RC clock input.
// (R2) A 3-bit select sets the period from 2^8 up to 2^15 slow periods.
// (R3) Key 10101B disables the watchdog and key 01010B enables it.
// (R4) Any other key value causes a full device reset after a delay.
// (R5) That reset sets the key fault flag, cleared only by writing zero.
// (R6) After power-on the key is the enable code and the select is 011.
// (R7) Overflow in normal running resets the device and sets expiry.
// (R8) Overflow in sleep or idle sets expiry and resets only PC and SP.
// (R9) The count clears on key fault reset, clear instruction or halt.
// (R10) Software must run the clear instruction within each period.
// (R11) Bits 7 to 3 of the reset cause register read as zero.
// (R12) Halt clears the count, which then runs only if enabled.
// (R13) Halt clears the expiry flag and sets the power-down flag.
// (R14) The key fault delay is a parameter counted in slow periods.
//
// Decided for this implementation: the Wishbone register port and the register addresses.
`include "kwd_defines.svh"

module kwd_watchdog #(
	parameter int unsigned KEY_FAULT_DELAY = `KWD_KEYFAULT_DELAY,
	parameter int unsigned DELAY_W         = 16
) (
	input  wire logic        MCLK,
	input  wire logic        RST_B,
	input  wire logic        SLOW_RC_CLK,
	input  wire logic        CLEAR_INSTR,
	input  wire logic        HALT_INSTR,
	input  wire logic        LOW_POWER,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [4:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	output logic             DEVICE_RESET,
	output logic             CORE_RESET,
	output logic             EXPIRY_FLAG,
	output logic             POWERDOWN_FLAG,
	output logic             IRQ
);

	localparam logic [DELAY_W-1:0] DELAY_LAST =
		DELAY_W'(KEY_FAULT_DELAY - 1);
	// widest count: base exponent plus the largest select code
	localparam int unsigned CNT_W = `KWD_CNT_W;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic                        slow_q;
	logic                        next_slow_q;
	logic                        tick;
	logic                        req;
	logic                        wr;
	logic [2:0]                  idx;
	logic [31:0]                 rd_data;
	logic [31:0]                 next_dat;
	logic                        next_ack;
	logic [7:0]                  ctrl;
	logic [7:0]                  next_ctrl;
	kwd_pkg::kwd_key_state_type  state;
	kwd_pkg::kwd_key_state_type  next_state;
	logic [DELAY_W-1:0]          delay;
	logic [DELAY_W-1:0]          next_delay;
	logic                        fire;
	logic                        next_fire;
	logic                        key_fault;
	logic                        next_key_fault;
	logic                        next_expiry;
	logic                        next_pdown;
	logic [`KWD_IRQ_W-1:0]       irq_stat;
	logic [`KWD_IRQ_W-1:0]       next_irq_stat;
	logic [`KWD_IRQ_W-1:0]       irq_mask;
	logic [`KWD_IRQ_W-1:0]       next_irq_mask;
	logic [`KWD_IRQ_W-1:0]       events;
	logic                        next_irq;
	logic                        next_dev_rst;
	logic                        next_core_rst;
	logic [4:0]                  new_key;

	kwd_cnt_if #(.CNT_W(CNT_W)) cnt_if ();

	// ----------------------------------------------------------------
	// slow clock edge detect
	// ----------------------------------------------------------------
	// the slow clock is sampled, so it must stay well below MCLK/2
	always_comb
	begin
		next_slow_q = SLOW_RC_CLK;
	end

	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			// held high so a clock already high at release gives no tick
			slow_q <= 1'b1;
		end
		else
		begin
			slow_q <= next_slow_q;
		end
	end

	assign tick = SLOW_RC_CLK & ~slow_q; // (R1)

	// ----------------------------------------------------------------
	// wishbone slave
	// ----------------------------------------------------------------
	// one wait state: request taken with ack low, ack one cycle later
	assign req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	assign wr = req & WB_WE_I & WB_SEL_I[0];
	assign idx = WB_ADR_I[4:2];

	// read mux, unmapped words read zero
	always_comb
	begin
		rd_data = 32'h0000_0000;
		unique case (idx)
			`KWD_ADR_CTRL:
				rd_data[7:0] = ctrl;
			`KWD_ADR_CAUSE:
				rd_data[`KWD_CAUSE_KEYFAULT] = key_fault; // (R11)
			`KWD_ADR_STAT:
			begin
				rd_data[`KWD_STAT_EXPIRY] = EXPIRY_FLAG;
				rd_data[`KWD_STAT_PDOWN] = POWERDOWN_FLAG;
			end
			`KWD_ADR_IRQ_STAT:
				rd_data[`KWD_IRQ_W-1:0] = irq_stat;
			`KWD_ADR_IRQ_MASK:
				rd_data[`KWD_IRQ_W-1:0] = irq_mask;
			`KWD_ADR_COUNT:
				rd_data[CNT_W-1:0] = cnt_if.count;
			default:
				rd_data = 32'h0000_0000;
		endcase
	end

	// answer every request, mapped or not
	always_comb
	begin
		next_ack = req;
		next_dat = WB_DAT_O;
		if (req)
		begin
			next_dat = rd_data;
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end
		else
		begin
			WB_ACK_O <= next_ack;
			WB_DAT_O <= next_dat;
		end
	end

	// ----------------------------------------------------------------
	// control register and key decoder
	// ----------------------------------------------------------------
	// a bad key commits to the reset; rewriting a good key cannot stop it
	always_comb
	begin
		next_ctrl = ctrl;
		next_state = state;
		next_delay = delay;
		next_fire = 1'b0;
		if (wr && idx == `KWD_ADR_CTRL)
		begin
			next_ctrl = WB_DAT_I[7:0];
		end
		new_key = next_ctrl[`KWD_KEY_MSB:`KWD_KEY_LSB];
		unique case (state)
			kwd_pkg::KS_ENABLED, kwd_pkg::KS_DISABLED:
			begin
				next_delay = '0;
				if (new_key == `KWD_KEY_ENABLE)
				begin
					next_state = kwd_pkg::KS_ENABLED; // (R3)
				end
				else if (new_key == `KWD_KEY_DISABLE)
				begin
					next_state = kwd_pkg::KS_DISABLED; // (R3)
				end
				else
				begin
					next_state = kwd_pkg::KS_FAULT; // (R4)
				end
			end
			kwd_pkg::KS_FAULT:
			begin
				if (tick)
				begin
					if (delay == DELAY_LAST) // (R14)
					begin
						next_fire = 1'b1; // (R4)
						next_delay = '0;
						next_ctrl = `KWD_CTRL_RESET;
						next_state = kwd_pkg::KS_ENABLED;
					end
					else
					begin
						next_delay = delay + 1'b1;
					end
				end
			end
		endcase
	end

	// power-on values: key enabled, middle period select
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			ctrl <= `KWD_CTRL_RESET; // (R6)
			state <= kwd_pkg::KS_ENABLED; // (R6)
			delay <= '0;
			fire <= 1'b0;
		end
		else
		begin
			ctrl <= next_ctrl;
			state <= next_state;
			delay <= next_delay;
			fire <= next_fire;
		end
	end

	// ----------------------------------------------------------------
	// period counter
	// ----------------------------------------------------------------
	assign cnt_if.tick = tick;
	assign cnt_if.sel = ctrl[`KWD_SEL_MSB:`KWD_SEL_LSB]; // (R2)
	assign cnt_if.run = (state == kwd_pkg::KS_ENABLED); // (R12)
	// halt, clear instruction and key fault reset clear the count
	assign cnt_if.clear = CLEAR_INSTR | HALT_INSTR | fire; // (R9) (R12)

	// a pending key fault stops the count, so no expiry races that reset
	kwd_counter #(
		.CNT_W (CNT_W)
	) kwd_counter_inst (
		.clk   (MCLK),
		.rst_n (RST_B),
		.port  (cnt_if)
	);

	// ----------------------------------------------------------------
	// flags, resets and interrupt
	// ----------------------------------------------------------------
	assign events[`KWD_IRQ_EXPIRY] = cnt_if.expire;
	assign events[`KWD_IRQ_KEYFAULT] = fire;

	// in every flag a hardware set wins over a clear in the same cycle
	always_comb
	begin
		next_key_fault = key_fault;
		next_expiry = EXPIRY_FLAG;
		next_pdown = POWERDOWN_FLAG;
		next_irq_stat = irq_stat;
		next_irq_mask = irq_mask;
		next_dev_rst = 1'b0;
		next_core_rst = 1'b0;
		// only a written zero clears, a written one is ignored
		if (wr && idx == `KWD_ADR_CAUSE
			&& !WB_DAT_I[`KWD_CAUSE_KEYFAULT])
		begin
			next_key_fault = 1'b0; // (R5)
		end
		if (fire)
		begin
			next_key_fault = 1'b1; // (R5)
			next_dev_rst = 1'b1; // (R4)
		end
		// clear instruction ends the power-down indication
		if (CLEAR_INSTR)
		begin
			next_pdown = 1'b0;
		end
		if (HALT_INSTR)
		begin
			next_expiry = 1'b0; // (R13)
			next_pdown = 1'b1; // (R13)
		end
		if (cnt_if.expire)
		begin
			next_expiry = 1'b1; // (R7) (R8)
			if (LOW_POWER)
			begin
				next_core_rst = 1'b1; // (R8)
			end
			else
			begin
				next_dev_rst = 1'b1; // (R7)
			end
		end
		if (wr && idx == `KWD_ADR_IRQ_MASK)
		begin
			next_irq_mask = WB_DAT_I[`KWD_IRQ_W-1:0];
		end
		if (wr && idx == `KWD_ADR_IRQ_STAT)
		begin
			next_irq_stat = irq_stat & ~WB_DAT_I[`KWD_IRQ_W-1:0];
		end
		next_irq_stat = next_irq_stat | events;
		next_irq = |(next_irq_stat & next_irq_mask);
	end

	// reset pulses last one cycle; the host decides what they reset
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			key_fault <= 1'b0;
			EXPIRY_FLAG <= 1'b0;
			POWERDOWN_FLAG <= 1'b0;
			irq_stat <= '0;
			irq_mask <= '0;
			IRQ <= 1'b0;
			DEVICE_RESET <= 1'b0;
			CORE_RESET <= 1'b0;
		end
		else
		begin
			key_fault <= next_key_fault;
			EXPIRY_FLAG <= next_expiry;
			POWERDOWN_FLAG <= next_pdown;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			IRQ <= next_irq;
			DEVICE_RESET <= next_dev_rst;
			CORE_RESET <= next_core_rst;
		end
	end

endmodule // kwd_watchdog

// ===== kwd_watchdog_sva.sv
// port-level assertions and covers for the keyed watchdog
module kwd_chk (
	input wire logic MCLK,
	input wire logic RST_B,
	input wire logic CLEAR_INSTR,
	input wire logic HALT_INSTR,
	input wire logic LOW_POWER,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_ACK_O,
	input wire logic DEVICE_RESET,
	input wire logic CORE_RESET,
	input wire logic EXPIRY_FLAG,
	input wire logic POWERDOWN_FLAG,
	input wire logic IRQ
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_B);

	// ----------------------------------------
	// bus and reset pulses
	// ----------------------------------------
	bus_ack_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
		|=> WB_ACK_O) else $error("request not acked next cycle");
	reset_pulse_a: assert property (DEVICE_RESET |=> !DEVICE_RESET)
		else $error("device reset longer than one cycle");
	core_cause_a: assert property (CORE_RESET |-> EXPIRY_FLAG
		&& !DEVICE_RESET && $past(LOW_POWER))
		else $error("core reset without sleep expiry");
	expiry_set_a: assert property ($rose(EXPIRY_FLAG) |->
		DEVICE_RESET || CORE_RESET) else $error("expiry without reset");

	// ----------------------------------------
	// halt and clear effects on the flags
	// ----------------------------------------
	halt_flags_a: assert property (HALT_INSTR |=> POWERDOWN_FLAG &&
		(!EXPIRY_FLAG || DEVICE_RESET || CORE_RESET))
		else $error("halt flags wrong");
	pdown_set_a: assert property ($rose(POWERDOWN_FLAG) |->
		$past(HALT_INSTR)) else $error("power-down set without halt");
	expiry_clr_a: assert property ($fell(EXPIRY_FLAG) |->
		$past(HALT_INSTR) || !$past(RST_B))
		else $error("expiry cleared without halt");
	clear_pd_a: assert property (CLEAR_INSTR && !HALT_INSTR |=>
		!POWERDOWN_FLAG) else $error("clear left power-down set");

	// main scenarios reached
	cover property ($rose(DEVICE_RESET));
	cover property ($rose(CORE_RESET));
	cover property ($rose(IRQ));
endmodule // kwd_chk

bind kwd_watchdog kwd_chk kwd_chk_inst (.MCLK, .RST_B, .CLEAR_INSTR,
	.HALT_INSTR, .LOW_POWER, .WB_CYC_I, .WB_STB_I, .WB_ACK_O,
	.DEVICE_RESET, .CORE_RESET, .EXPIRY_FLAG, .POWERDOWN_FLAG, .IRQ);

// ===== kwd_watchdog_bench.sv
// self-checking bench for the keyed watchdog
module kwd_watchdog_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        MCLK = 1'b0;
	logic        RST_B = 1'b0;
	logic        SLOW_RC_CLK = 1'b0;
	logic        CLEAR_INSTR = 1'b0;
	logic        HALT_INSTR = 1'b0;
	logic        LOW_POWER = 1'b0;
	logic        WB_CYC_I = 1'b0;
	logic        WB_STB_I = 1'b0;
	logic        WB_WE_I = 1'b0;
	logic [4:0]  WB_ADR_I = 5'h00;
	logic [3:0]  WB_SEL_I = 4'h0;
	logic [31:0] WB_DAT_I = 32'h0;
	logic [31:0] WB_DAT_O;
	logic        WB_ACK_O, DEVICE_RESET, CORE_RESET;
	logic        EXPIRY_FLAG, POWERDOWN_FLAG, IRQ;
	logic [1:0]  div = 2'h0;
	logic        slow_q = 1'b0;
	logic [31:0] q, a;
	int          ticks = 0, dev_n = 0, t0, error_cnt = 0, checks = 0;

	// short key fault delay keeps that scenario brief
	localparam int KF_DELAY = 2;
	kwd_watchdog #(.KEY_FAULT_DELAY(KF_DELAY)) kwd_watchdog_inst (.MCLK,
		.RST_B, .SLOW_RC_CLK, .CLEAR_INSTR, .HALT_INSTR, .LOW_POWER,
		.WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I,
		.WB_DAT_O, .WB_ACK_O, .DEVICE_RESET, .CORE_RESET, .EXPIRY_FLAG,
		.POWERDOWN_FLAG, .IRQ);

	initial
		forever #5 MCLK = ~MCLK;

	// slow clock at a quarter rate; tick count mirrors the edge detector
	always @(posedge MCLK)
	begin
		div <= div + 2'h1;
		SLOW_RC_CLK <= div[1];
		slow_q <= SLOW_RC_CLK;
		if (SLOW_RC_CLK && !slow_q)
			ticks <= ticks + 1;
		if (DEVICE_RESET)
			dev_n <= dev_n + 1;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, e, input string m);
		checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask

	// one classic cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [4:0] ad,
		input logic [7:0] d);
		int n;
		n = 0;
		@(posedge MCLK);
		WB_CYC_I <= 1'b1;
		WB_STB_I <= 1'b1;
		WB_WE_I <= w;
		WB_ADR_I <= ad;
		WB_SEL_I <= 4'hF;
		WB_DAT_I <= {24'h0, d};
		do
		begin
			@(posedge MCLK);
			n++;
		end while (WB_ACK_O !== 1'b1 && n < 20);
		q = WB_DAT_O;
		WB_CYC_I <= 1'b0;
		WB_STB_I <= 1'b0;
		if (n >= 20)
		begin
			chk(32'h0, 32'h1, "no bus ack");
			tally_and_finish;
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge MCLK);
		#1;
	endtask

	// bit 0 device reset, bit 1 core reset; bounded wait
	task automatic wait_for(input int b, input int lim);
		logic [1:0] o;
		o = 2'h0;
		for (int i = 0; i < lim && o[b] !== 1'b1; i++)
		begin
			cyc(1);
			o = {CORE_RESET, DEVICE_RESET};
		end
		if (o[b] !== 1'b1)
		begin
			chk(32'h0, 32'h1, "event timeout");
			tally_and_finish;
		end
	endtask

	task automatic pulse(input logic h);
		@(posedge MCLK);
		if (h)
			HALT_INSTR <= 1'b1;
		else
			CLEAR_INSTR <= 1'b1;
		@(posedge MCLK);
		HALT_INSTR <= 1'b0;
		CLEAR_INSTR <= 1'b0;
		#1;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial
	begin
		repeat (6) @(posedge MCLK);
		RST_B <= 1'b1;
		wb(0, 5'h00, 8'h00);
		chk(q, 32'h53, "control reset");
		wb(0, 5'h04, 8'h00);
		chk(q, 32'h0, "cause reset");
		wb(0, 5'h1C, 8'h00);
		chk(q, 32'h0, "unmapped read");
		wb(1, 5'h10, 8'h01);
		// shortest period, cleared well inside it three times
		wb(1, 5'h00, 8'h50);
		a = dev_n;
		repeat (3)
		begin
			cyc(900);
			pulse(1'b0);
		end
		chk(dev_n, a, "reset despite clears");
		for (int s = 0; s < 5; s++)
		begin
			wb(1, 5'h00, {5'h0A, s[2:0]});
			pulse(1'b0);
			t0 = ticks;
			wait_for(0, (1024 << s) + 99);
			chk(ticks - t0, 256 << s, "period");
			chk(EXPIRY_FLAG, 1'b1, "expiry flag");
		end
		chk(IRQ, 1'b1, "irq raised");
		wb(1, 5'h10, 8'h00);
		cyc(1);
		chk(IRQ, 1'b0, "irq masked");
		wb(1, 5'h0C, 8'h03);
		wb(0, 5'h0C, 8'h00);
		chk(q, 32'h0, "irq status cleared");
		// short period so the sleep expiry comes soon
		wb(1, 5'h00, 8'h50);
		LOW_POWER <= 1'b1;
		pulse(1'b0);
		wait_for(1, 1100);
		chk(DEVICE_RESET, 1'b0, "full reset in sleep");
		chk(EXPIRY_FLAG, 1'b1, "expiry in sleep");
		@(posedge MCLK);
		LOW_POWER <= 1'b0;
		pulse(1'b1);
		chk(POWERDOWN_FLAG, 1'b1, "pdown set");
		chk(EXPIRY_FLAG, 1'b0, "expiry cleared");
		wb(0, 5'h08, 8'h00);
		chk(q, 32'h2, "status word");
		wb(0, 5'h14, 8'h00);
		chk(q < 32'h4, 1'b1, "count after halt");
		pulse(1'b0);
		chk(POWERDOWN_FLAG, 1'b0, "pdown cleared");
		wb(1, 5'h00, 8'hA8);
		pulse(1'b1);
		a = dev_n;
		cyc(1100);
		wb(0, 5'h14, 8'h00);
		chk(q, 32'h0, "count held");
		chk(dev_n, a, "reset while off");
		wb(1, 5'h00, 8'h00);
		t0 = ticks;
		wait_for(0, 99);
		chk(ticks - t0, KF_DELAY, "key fault delay");
		wb(0, 5'h04, 8'h00);
		chk(q, 32'h1, "key fault flag");
		wb(0, 5'h00, 8'h00);
		chk(q, 32'h53, "control reloaded");
		wb(0, 5'h0C, 8'h00);
		chk({q[31:1], IRQ}, 32'h2, "masked events");
		wb(1, 5'h04, 8'hFF);
		wb(0, 5'h04, 8'h00);
		chk(q, 32'h1, "cause after write one");
		wb(1, 5'h04, 8'h00);
		wb(0, 5'h04, 8'h00);
		chk(q, 32'h0, "cause cleared");
		tally_and_finish;
	end
endmodule // kwd_watchdog_bench
